// *** fpd_pkg.sv ***
// Package for the fieldbus process-data map: frame sizes, byte positions,
// register offsets and timing counts.
// Assumes a 200 MHz system clock.
`default_nettype none
package fpd_pkg;
   // Frame sizes in bytes
   localparam int FRAME_EXT1 = 32;
   localparam int FRAME_EXT2 = 12;
   localparam int FRAME_BASIC = 6;
   // Layout codes
   localparam logic [1:0] LAYOUT_BASIC = 2'h0;
   localparam logic [1:0] LAYOUT_EXT1 = 2'h1;
   localparam logic [1:0] LAYOUT_EXT2 = 2'h2;
   // Control method codes
   localparam logic [3:0] CM_VF = 4'h0;
   localparam logic [3:0] CM_CLOSED_LOOP_VECTOR = 4'h3;
   localparam logic [3:0] CM_OPEN_LOOP_VECTOR_PM = 4'h5;
   localparam logic [3:0] CM_ADVANCED_OPEN_LOOP_PM = 4'h6;
   localparam logic [3:0] CM_CLOSED_LOOP_VECTOR_PM = 4'h7;
   // Byte positions, extended layout one
   localparam int E1_MSG_BASE = 16;
   localparam int E1_HANDSHAKE = 31;
   // Byte positions, extended layout two
   localparam int E2_MSG_BASE = 4;
   localparam int E2_HANDSHAKE = 11;
   // Forwarding deadline
   localparam int FORWARD_MS = 2;
   localparam int CLK_HZ = 200_000_000;
   localparam int FORWARD_CYCLES = FORWARD_MS * (CLK_HZ / 1000);
   // Wishbone register offsets
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_CMD = 8'h10;
   localparam logic [7:0] REG_FREQ = 8'h14;
   localparam logic [7:0] REG_TORQUE = 8'h18;
   localparam logic [7:0] REG_DRV_STATUS = 8'h1C;
   localparam logic [7:0] REG_MOTOR_SPEED = 8'h20;
   localparam logic [7:0] REG_OUT_CURRENT = 8'h24;
   // Config field positions
   localparam int CFG_FORMAT_BIT = 0;
   localparam int CFG_TSRC_BIT = 1;
   localparam int CFG_TCTL_BIT = 2;
   localparam int CFG_SCALE_BIT = 3;
   localparam int CFG_LARGE_BIT = 4;
   localparam int CFG_CM_LSB = 8;
   localparam int CFG_LAYOUT_LSB = 12;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   // Interrupt bit positions
   localparam int IRQ_FRAME_BIT = 0;
   localparam int IRQ_CMD_BIT = 1;
   localparam int IRQ_FAULT_BIT = 2;
endpackage
`default_nettype wire

// *** fpd_map.sv ***
// Process-data framer: latches output frames from the fieldbus, decodes
// fields into drive commands, and builds input frames from drive monitors.
// Assumes byte strobes from fieldbus logic on the same clock.
//
// Functional notes
// - Layout selects 32, 12 or 6 byte frames, both directions
// - Conventional format used only when data format select equals one
// - Run and frequency reference reach drive within 2 ms
// - Sixteen-bit fields put high byte first, low byte next
// - Basic output: command, frequency reference, torque field
// - Basic input: status, motor speed, output current
// - Torque fields honoured only in the three vector control methods
// - Torque source enables; control select picks limit or reference (always limit here under closed-loop vector PM)
// - Speed monitor scaled; output frequency under V/f or open-loop PM
// - Current in 0.01 A up to 7.5 kW, else 0.1 A
// - Extended one output bytes 0 to 15 decoded as fixed fields
// - Extended one input bytes 0 to 15 filled from monitors
// - Extended one bytes 16 to 31 form the message area
// - Extended two: four I/O bytes then eight message bytes
// - Command bits: run, direction, inputs, fault, reset, baseblock
// - Status bits from running through network control
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`default_nettype none
module fpd_map (
   input wire logic clk_i,
   input wire logic rst_i,
   // Output frame byte stream from the fieldbus
   input wire logic rx_valid_i,
   input wire logic [4:0] rx_index_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_end_i,
   // Input frame byte read port to the fieldbus
   input wire logic [4:0] tx_index_i,
   output logic [7:0] tx_byte_o,
   // Drive command side
   output logic run_o,
   output logic reverse_o,
   output logic [5:0] multi_input_o,
   output logic network_external_fault_o,
   output logic fault_reset_o,
   output logic fault_history_reset_o,
   output logic baseblock_o,
   output logic [15:0] freq_ref_o,
   output logic [15:0] torque_ref_o,
   output logic torque_ref_valid_o,
   output logic [15:0] torque_limit_o,
   output logic torque_limit_valid_o,
   output logic [15:0] torque_comp_o,
   output logic [15:0] analog_out1_o,
   output logic [15:0] analog_out2_o,
   output logic [15:0] digital_out_o,
   output logic cmd_update_o,
   // Message area toward and from the message engine
   output logic [7:0] msg_out_o [0:15],
   output logic msg_update_o,
   input wire logic [7:0] msg_in_i [0:15],
   // Drive monitors
   input wire logic [15:0] drive_status_i,
   input wire logic [15:0] motor_speed_i,
   input wire logic [15:0] out_freq_i,
   input wire logic [15:0] out_current_raw_i,
   input wire logic [15:0] torque_mon_i,
   input wire logic [15:0] pulse_count_i,
   input wire logic [15:0] freq_ref_mon_i,
   input wire logic [15:0] analog_in1_i,
   input wire logic [15:0] speed_scale_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o
);
   localparam int FWD_W = $clog2(fpd_pkg::FORWARD_CYCLES + 1);

   logic [7:0] shadow [0:31];
   logic [7:0] frame [0:31];
   logic [31:0] config_reg;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [FWD_W-1:0] fwd_count;
   logic frame_pending;
   logic [15:0] cmd_word;
   logic [15:0] freq_word;
   logic [15:0] torque_word;
   // Set when a latched frame has not been applied in time
   wire fwd_late = fwd_count == FWD_W'(fpd_pkg::FORWARD_CYCLES);

   // Config fields
   wire data_format_select = config_reg[fpd_pkg::CFG_FORMAT_BIT];
   wire network_torque_source_select = config_reg[fpd_pkg::CFG_TSRC_BIT];
   wire torque_control_select = config_reg[fpd_pkg::CFG_TCTL_BIT];
   wire display_scaling_select = config_reg[fpd_pkg::CFG_SCALE_BIT];
   wire large_drive = config_reg[fpd_pkg::CFG_LARGE_BIT];
   wire [3:0] control_method_select =
      config_reg[fpd_pkg::CFG_CM_LSB +: 4];
   wire [1:0] layout = config_reg[fpd_pkg::CFG_LAYOUT_LSB +: 2];

   wire [4:0] last_byte =
      (layout == fpd_pkg::LAYOUT_EXT1) ? 5'(fpd_pkg::FRAME_EXT1 - 1) :
      (layout == fpd_pkg::LAYOUT_EXT2) ? 5'(fpd_pkg::FRAME_EXT2 - 1) :
      5'(fpd_pkg::FRAME_BASIC - 1);
   wire is_ext1 = layout == fpd_pkg::LAYOUT_EXT1;
   wire is_ext2 = layout == fpd_pkg::LAYOUT_EXT2;
   wire is_basic = layout == fpd_pkg::LAYOUT_BASIC;

   // Wishbone decode
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i & (&wb_sel_i);
   wire wr_config = wb_wr & (wb_adr_i == fpd_pkg::REG_CONFIG);
   wire wr_irq_stat = wb_wr & (wb_adr_i == fpd_pkg::REG_IRQ_STAT);
   wire wr_irq_mask = wb_wr & (wb_adr_i == fpd_pkg::REG_IRQ_MASK);

   // high byte at lower byte number
   function automatic logic [15:0] pair(input logic [7:0] hi,
                                        input logic [7:0] lo);
      pair = {hi, lo};
   endfunction

   wire frame_done = rx_end_i & data_format_select;

   // fields come from the latched frame only
   wire [15:0] next_cmd = pair(frame[0], frame[1]);
   wire [15:0] next_freq = pair(frame[2], frame[3]);
   wire [15:0] next_torque = is_ext2 ? 16'h0000 : pair(frame[4], frame[5]);

   // torque only in the three vector methods
   wire torque_method_ok =
      (control_method_select == fpd_pkg::CM_CLOSED_LOOP_VECTOR) |
      (control_method_select == fpd_pkg::CM_ADVANCED_OPEN_LOOP_PM) |
      (control_method_select == fpd_pkg::CM_CLOSED_LOOP_VECTOR_PM);
   // source enable, limit or reference choice
   wire torque_en = torque_method_ok & network_torque_source_select &
                    ~is_ext2;
   wire torque_as_ref = torque_control_select &
      (control_method_select != fpd_pkg::CM_CLOSED_LOOP_VECTOR_PM);

   wire speed_is_freq =
      (control_method_select == fpd_pkg::CM_VF) |
      (control_method_select == fpd_pkg::CM_OPEN_LOOP_VECTOR_PM);
   wire [31:0] speed_prod = motor_speed_i * speed_scale_i;
   wire [15:0] speed_word = speed_is_freq ? out_freq_i :
      (display_scaling_select ? speed_prod[23:8] : motor_speed_i);
   wire [15:0] current_word = large_drive ?
      16'(out_current_raw_i / 16'd10) : out_current_raw_i;
   wire [15:0] status_word = drive_status_i;

   logic [15:0] io_word;
   always_comb begin
      io_word = 16'h0000;
      unique case (tx_index_i[4:1])
         4'h0: io_word = status_word;
         4'h1: io_word = speed_word;
         4'h2: io_word = is_basic ? current_word : torque_mon_i;
         4'h3: io_word = pulse_count_i;
         4'h4: io_word = freq_ref_mon_i;
         4'h5: io_word = out_freq_i;
         4'h6: io_word = current_word;
         4'h7: io_word = analog_in1_i;
         default: io_word = 16'h0000;
      endcase
   end
   wire [7:0] io_byte = tx_index_i[0] ? io_word[7:0] : io_word[15:8];
   wire in_range = tx_index_i <= last_byte;
   wire [4:0] ext2_msg = 5'(tx_index_i - 5'(fpd_pkg::E2_MSG_BASE));
   wire [4:0] ext1_msg = 5'(tx_index_i - 5'(fpd_pkg::E1_MSG_BASE));
   wire reserved_in = (is_ext2 && tx_index_i == 5'd10) ||
      (is_ext1 && tx_index_i >= 5'd28 && tx_index_i <= 5'd30);
   wire [7:0] next_tx =
      (!in_range || reserved_in) ? 8'h00 :
      (is_ext1 && tx_index_i >= 5'(fpd_pkg::E1_MSG_BASE)) ?
         msg_in_i[ext1_msg[3:0]] :
      (is_ext2 && tx_index_i >= 5'(fpd_pkg::E2_MSG_BASE)) ?
         msg_in_i[ext2_msg[3:0]] :
      (is_ext2 && tx_index_i >= 5'd4) ? 8'h00 : io_byte;

   // Register read mux
   wire [31:0] rd_data =
      (wb_adr_i == fpd_pkg::REG_CONFIG) ? config_reg :
      (wb_adr_i == fpd_pkg::REG_STATUS) ?
         {28'h000_0000, fwd_late, frame_pending, layout} :
      (wb_adr_i == fpd_pkg::REG_IRQ_STAT) ? {29'h0000_0000, irq_stat} :
      (wb_adr_i == fpd_pkg::REG_IRQ_MASK) ? {29'h0000_0000, irq_mask} :
      (wb_adr_i == fpd_pkg::REG_CMD) ? {16'h0000, cmd_word} :
      (wb_adr_i == fpd_pkg::REG_FREQ) ? {16'h0000, freq_word} :
      (wb_adr_i == fpd_pkg::REG_TORQUE) ? {16'h0000, torque_word} :
      (wb_adr_i == fpd_pkg::REG_DRV_STATUS) ? {16'h0000, status_word} :
      (wb_adr_i == fpd_pkg::REG_MOTOR_SPEED) ? {16'h0000, speed_word} :
      (wb_adr_i == fpd_pkg::REG_OUT_CURRENT) ? {16'h0000, current_word} :
      32'h0000_0000;

   // Events
   wire cmd_event = frame_pending;
   wire fault_event = cmd_update_o & cmd_word[8];
   wire [2:0] irq_set = {fault_event, cmd_event, frame_done};

   // Receive shadow: bytes beyond the frame length are dropped
   always_ff @(posedge clk_i) begin
      if (rx_valid_i && rx_index_i <= last_byte) begin
         shadow[rx_index_i] <= rx_byte_i;
      end
   end

   // whole frame copied at end of frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++) begin
            frame[i] <= 8'h00;
         end
      end else if (frame_done) begin
         for (int i = 0; i < 32; i++) begin
            frame[i] <= (i <= int'(last_byte)) ? shadow[i] : 8'h00;
         end
      end
   end

   // frame applied one cycle after latching, far under 2 ms
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_pending <= 1'b0;
         cmd_word <= 16'h0000;
         freq_word <= 16'h0000;
         torque_word <= 16'h0000;
         cmd_update_o <= 1'b0;
         msg_update_o <= 1'b0;
      end else begin
         frame_pending <= frame_done;
         cmd_update_o <= frame_pending;
         msg_update_o <= frame_pending & ~is_basic;
         if (frame_pending) begin
            cmd_word <= next_cmd;
            freq_word <= next_freq;
            torque_word <= next_torque;
         end
      end
   end

   // Deadline watch: counts from frame end until commands applied
   always_ff @(posedge clk_i) begin
      if (rst_i || cmd_update_o) begin
         fwd_count <= '0;
      end else if (frame_done || fwd_count != '0) begin
         if (fwd_count != FWD_W'(fpd_pkg::FORWARD_CYCLES)) begin
            fwd_count <= fwd_count + 1'b1;
         end
      end
   end

   assign run_o = cmd_word[0];
   assign reverse_o = cmd_word[1];
   assign multi_input_o = cmd_word[7:2];
   assign network_external_fault_o = cmd_word[8];
   assign fault_reset_o = cmd_word[9];
   assign baseblock_o = cmd_word[15];
   assign freq_ref_o = freq_word;

   // history reset on rising edge of bit E
   logic hist_prev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hist_prev <= 1'b0;
         fault_history_reset_o <= 1'b0;
      end else begin
         hist_prev <= cmd_word[14];
         fault_history_reset_o <= cmd_word[14] & ~hist_prev;
      end
   end

   // output field decode, bytes 8-9 ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         torque_ref_o <= 16'h0000;
         torque_limit_o <= 16'h0000;
         torque_ref_valid_o <= 1'b0;
         torque_limit_valid_o <= 1'b0;
         torque_comp_o <= 16'h0000;
         analog_out1_o <= 16'h0000;
         analog_out2_o <= 16'h0000;
         digital_out_o <= 16'h0000;
      end else if (frame_pending) begin
         torque_ref_valid_o <= torque_en & torque_as_ref;
         torque_limit_valid_o <= torque_en & ~torque_as_ref;
         if (torque_en & torque_as_ref) begin
            torque_ref_o <= next_torque;
         end
         if (torque_en & ~torque_as_ref) begin
            torque_limit_o <= next_torque;
         end
         if (is_ext1) begin
            torque_comp_o <= torque_method_ok ?
               pair(frame[6], frame[7]) : 16'h0000;
            analog_out1_o <= pair(frame[10], frame[11]);
            analog_out2_o <= pair(frame[12], frame[13]);
            digital_out_o <= pair(frame[14], frame[15]);
         end
      end
   end

   // message area out; handshake byte carried
   genvar g;
   for (g = 0; g < 16; g++) begin : g_msg
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            msg_out_o[g] <= 8'h00;
         end else if (frame_pending && is_ext1) begin
            msg_out_o[g] <= frame[fpd_pkg::E1_MSG_BASE + g];
         end else if (frame_pending && is_ext2) begin
            msg_out_o[g] <= (g < 8) ? frame[fpd_pkg::E2_MSG_BASE + g] :
               8'h00;
         end
      end
   end

   // Transmit byte register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_byte_o <= 8'h00;
      end else begin
         tx_byte_o <= next_tx;
      end
   end

   // Registers, interrupts and bus answer; set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         config_reg <= fpd_pkg::CONFIG_RESET;
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= rd_data;
         end
         if (wr_config) begin
            config_reg <= wb_dat_i;
         end
         if (wr_irq_mask) begin
            irq_mask <= wb_dat_i[2:0];
         end
         irq_stat <= (irq_stat & ~(wr_irq_stat ? wb_dat_i[2:0] : 3'h0))
                     | irq_set;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// *** fpd_map_props.sv ***
// Checker for the process-data framer: bus answer, forwarding delay,
// field stability, torque selection and reserved input bytes.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module fpd_map_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rx_end_i,
   input wire logic [4:0] tx_index_i,
   input wire logic [7:0] tx_byte_o,
   input wire logic run_o,
   input wire logic [15:0] freq_ref_o,
   input wire logic torque_ref_valid_o,
   input wire logic torque_limit_valid_o,
   input wire logic fault_history_reset_o,
   input wire logic cmd_update_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_bus_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1
         !wb_ack_o) else $error("bus answer late or held");
   a_ack_cause:
      assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_fwd_delay:
      assert property (cmd_update_o |-> $past(rx_end_i, 2))
      else $error("update not two cycles after frame end");
   a_update_pulse:
      assert property (cmd_update_o |=> !cmd_update_o)
      else $error("update pulse too long");
   a_fields_hold:
      assert property (!cmd_update_o |-> $stable(run_o) && $stable(freq_ref_o))
      else $error("fields moved without update");
   a_torque_one:
      assert property (!(torque_ref_valid_o && torque_limit_valid_o))
      else $error("torque both reference and limit");
   a_history_pulse:
      assert property (fault_history_reset_o |=> !fault_history_reset_o)
      else $error("history reset pulse too long");
   a_reserved_zero:
      assert property (tx_index_i >= 5'h1C && tx_index_i <= 5'h1E |=>
         tx_byte_o == 8'h00) else $error("reserved input byte not zero");
   c_run: cover property (cmd_update_o && run_o);
   c_limit: cover property (torque_limit_valid_o);
   c_ack: cover property (wb_ack_o);
endmodule
bind fpd_map fpd_map_props u_props (.clk_i, .rst_i, .rx_end_i, .tx_index_i,
   .tx_byte_o, .run_o, .freq_ref_o, .torque_ref_valid_o,
   .torque_limit_valid_o, .fault_history_reset_o, .cmd_update_o, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o);
`default_nettype wire

// *** fpd_master_model.sv ***
// Fieldbus master model: sends one output frame byte by byte.
// Assumes the framer samples bytes on the rising edge of clk_i.
`default_nettype none
module fpd_master_model (
   input wire logic clk_i,
   output logic rx_valid_o,
   output logic [4:0] rx_index_o,
   output logic [7:0] rx_byte_o,
   output logic rx_end_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_valid_o = 1'b0;
      rx_index_o = 5'h00;
      rx_byte_o = 8'h00;
      rx_end_o = 1'b0;
   end
   // message area sent as is, no reply assumed
   task automatic send(input logic [7:0] b [0:31], input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_index_o <= 5'(i);
         rx_byte_o <= b[i];
         repeat (gap) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            rx_byte_o <= ~b[i];
         end
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~rx_byte_o;
      rx_end_o <= 1'b1;
      @(posedge clk_i);
      rx_end_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** tb_fpd_map.sv ***
// Testbench for the process-data framer: bus set-up, frames from the
// master model, field and input-byte checks through queues.
// Assumes the package, framer, model and checker are compiled first.
`default_nettype none
module tb_fpd_map;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rx_valid_i, rx_end_i, tx_req = 1'b0, tx_d1 = 1'b0, ext_seen = 1'b0;
   logic [4:0] rx_index_i, tx_index_i = 5'h00;
   logic [7:0] rx_byte_i, tx_byte_o, wb_adr_i = 8'h00;
   logic run_o, reverse_o, network_external_fault_o, fault_reset_o;
   logic fault_history_reset_o, baseblock_o, torque_ref_valid_o;
   logic torque_limit_valid_o, cmd_update_o, msg_update_o, wb_ack_o, irq_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, seed = 32'h0000_1139;
   logic [5:0] multi_input_o;
   logic [15:0] freq_ref_o, torque_ref_o, torque_limit_o, torque_comp_o;
   logic [15:0] analog_out1_o, analog_out2_o, digital_out_o;
   logic [15:0] drive_status_i, motor_speed_i, out_freq_i, out_current_raw_i;
   logic [15:0] torque_mon_i, pulse_count_i, freq_ref_mon_i, analog_in1_i;
   logic [15:0] speed_scale_i = 16'h0100;
   logic [7:0] msg_out_o [0:15];
   logic [7:0] msg_in_i [0:15];
   logic [7:0] fr [0:31];
   logic [7:0] ex [0:31];
   logic [63:0] cmd_q [$];
   logic [31:0] rd_q [$];
   logic [7:0] tx_q [$];
   logic hq [$];
   logic [1:0] lay_now = 2'h0;
   logic upd_d1 = 1'b0, h_last = 1'b0;
   logic [3:0] cms [5] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h7};
   int miscompares = 0;
   int total_checks = 0;
   wire logic [15:0] tq = torque_ref_valid_o ? torque_ref_o :
      torque_limit_valid_o ? torque_limit_o : 16'h0000;
   wire logic [63:0] cmd_seen = {19'h0, run_o, reverse_o, multi_input_o,
      network_external_fault_o, fault_reset_o, baseblock_o, freq_ref_o,
      torque_ref_valid_o, torque_limit_valid_o, tq};
   always #2.5 clk_i = ~clk_i;
   fpd_master_model u_mst (.clk_i, .rx_valid_o(rx_valid_i),
      .rx_index_o(rx_index_i), .rx_byte_o(rx_byte_i), .rx_end_o(rx_end_i));
   fpd_map u_dut (.*);
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [63:0] exp_cmd(logic [15:0] c, f, t, logic [3:0] cm,
                                 logic tc, ts);
      logic en, lim;
      en = ts && cm inside {4'h3, 4'h6, 4'h7};
      lim = en && (!tc || cm == 4'h7);
      return {19'h0, c[0], c[1], c[7:2], c[8], c[9], c[15], f, en && !lim,
         lim, en ? t : 16'h0000};
   endfunction
   task check(input string n, input logic [63:0] e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task results();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   task cfg(input logic [1:0] lay, input logic [3:0] cm, input logic tc, ts,
            fmt);
      lay_now = lay;
      wb(1'b1, fpd_pkg::REG_CONFIG, {18'h0, lay, cm, 3'h0, tc, 1'b1, tc, ts,
         fmt});
      rd(fpd_pkg::REG_CONFIG, {18'h0, lay, cm, 3'h0, tc, 1'b1, tc, ts, fmt});
   endtask
   task frame(input int n, input logic [3:0] cm, input logic tc, ts);
      logic [15:0] c;
      for (int i = 0; i < 32; i++) fr[i] = 8'(rnd());
      c = {fr[0], fr[1]};
      ext_seen |= c[8];
      hq.push_back(c[14] & ~h_last);
      h_last = c[14];
      cmd_q.push_back(exp_cmd(c, {fr[2], fr[3]}, {fr[4], fr[5]}, cm, tc,
         ts && n != 12));
      u_mst.send(fr, n, int'(c[0]));
      repeat (4) @(posedge clk_i);
   endtask
   task mon(input logic [3:0] cm, input logic big, input int n);
      logic [15:0] w [0:7];
      logic [15:0] sp, cur;
      logic [127:0] ws;
      for (int i = 0; i < 8; i++) w[i] = 16'(rnd());
      sp = cm == 4'h0 || cm == 4'h5 ? w[2] : w[1];
      cur = big ? w[3] / 16'h000A : w[3];
      ws = n == 32 ? {w[0], sp, w[4], w[5], w[6], w[2], cur, w[7]} :
         {w[0], sp, n == 6 ? cur : 16'h0000, 80'h0};
      for (int k = 0; k < 8; k++) begin
         ex[2*k] = ws[127-16*k -: 8];
         ex[2*k+1] = ws[119-16*k -: 8];
      end
      @(posedge clk_i);
      for (int i = 16; i < 32; i++) begin
         ex[i] = 8'(rnd());
         msg_in_i[i-16] <= ex[i];
         if (n == 12 && i < 24) ex[i-12] = i == 22 ? 8'h00 : ex[i];
         if (n != 32 || (i > 27 && i < 31)) ex[i] = 8'h00;
      end
      {drive_status_i, motor_speed_i, out_freq_i, out_current_raw_i} <=
         {w[0], w[1], w[2], w[3]};
      {torque_mon_i, pulse_count_i, freq_ref_mon_i, analog_in1_i} <=
         {w[4], w[5], w[6], w[7]};
   endtask
   task txchk(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         tx_index_i <= 5'(i);
         tx_req <= 1'b1;
         tx_q.push_back(ex[i]);
      end
      @(posedge clk_i);
      tx_req <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      tx_d1 <= tx_req;
      upd_d1 <= cmd_update_o;
      if (wb_ack_o === 1'b1 && !wb_we_i)
         check("read data", rd_q.size() ? rd_q.pop_front() : 'x, wb_dat_o);
      if (cmd_update_o === 1'b1)
         check("command", cmd_q.size() ? cmd_q.pop_front() : 'x, cmd_seen);
      if (tx_d1)
         check("input byte", tx_q.pop_front(), tx_byte_o);
      if (cmd_update_o === 1'b1)
         check("message update", lay_now != fpd_pkg::LAYOUT_BASIC,
            msg_update_o);
      if (upd_d1)
         check("history reset", hq.size() ? hq.pop_front() : 'x,
            fault_history_reset_o);
   end
   initial begin
      for (int i = 0; i < 16; i++) msg_in_i[i] = 8'h00;
      {drive_status_i, motor_speed_i, out_freq_i, out_current_raw_i} = '0;
      {torque_mon_i, pulse_count_i, freq_ref_mon_i, analog_in1_i} = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(fpd_pkg::REG_CONFIG, fpd_pkg::CONFIG_RESET);
      rd(8'hFC, 32'h0000_0000);
      wb(1'b1, fpd_pkg::REG_IRQ_MASK, 32'h0000_0002);
      foreach (cms[k]) for (int t = 0; t < 2; t++) begin
         cfg(fpd_pkg::LAYOUT_BASIC, cms[k], t[0], 1'b1, 1'b1);
         frame(6, cms[k], t[0], 1'b1);
         mon(cms[k], t[0], 6);
         txchk(8);
      end
      @(negedge clk_i);
      check("irq raised", 1'b1, irq_o);
      rd(fpd_pkg::REG_IRQ_STAT, {29'h0, ext_seen, 2'h3});
      wb(1'b1, fpd_pkg::REG_IRQ_STAT, 32'h0000_0007);
      rd(fpd_pkg::REG_IRQ_STAT, 32'h0000_0000);
      @(negedge clk_i);
      check("irq cleared", 1'b0, irq_o);
      cfg(fpd_pkg::LAYOUT_EXT1, 4'h3, 1'b1, 1'b1, 1'b1);
      frame(32, 4'h3, 1'b1, 1'b1);
      @(negedge clk_i);
      check("ext outputs", {fr[6], fr[7], fr[10], fr[11], fr[12], fr[13],
         fr[14], fr[15]}, {torque_comp_o, analog_out1_o, analog_out2_o,
         digital_out_o});
      for (int i = 0; i < 16; i++)
         check("message out", fr[16+i], msg_out_o[i]);
      mon(4'h3, 1'b1, 32);
      txchk(32);
      rd(fpd_pkg::REG_STATUS, 32'h0000_0001);
      wb(1'b1, fpd_pkg::REG_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(negedge clk_i);
      check("irq masked", 1'b0, irq_o);
      cfg(fpd_pkg::LAYOUT_EXT2, 4'h3, 1'b0, 1'b0, 1'b1);
      frame(12, 4'h3, 1'b0, 1'b0);
      mon(4'h3, 1'b0, 12);
      txchk(12);
      wb_sel_i <= 4'h3;
      wb(1'b1, fpd_pkg::REG_IRQ_MASK, 32'h0000_0007);
      wb_sel_i <= 4'hF;
      rd(fpd_pkg::REG_IRQ_MASK, 32'h0000_0000);
      cfg(fpd_pkg::LAYOUT_BASIC, 4'h3, 1'b1, 1'b1, 1'b0);
      u_mst.send(fr, 6, 0);
      repeat (6) @(posedge clk_i);
      results();
   end
   initial begin
      #100000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
